// ---- arf_pkg.sv ----
// Shared constants of the result buffer link and of both its ends
//------------------------------------------------------------------
// Behaviour
// - Sixteen-entry circular buffer fills without host action
// - Read pointer marks the next word read
// - Write pointer marks last stored; threshold pointer marks where the block's last word goes
// - Scanned channels stored in fixed repeating order
// - Block signalled when threshold count of words stored
// - Block signalled by one low pulse each; a block ending inside a running pulse only restarts it
// - Host reads exactly threshold count per pulse
// - One channel offers thresholds 1, 4, 8, 14
// - Each block starts with first scanned channel
// - Host strobes synchronised before touching the buffer
// - Read access is both selects and read strobe
// - Two ten-bit setup registers
// - Select bits 00 first, 01 second, others reserved
// - Host drives all ten data lines on writes
// - First register write-only, bits 11 and 10 zero
// - Bit 0 picks reference, resets to internal
// - Bit 1 picks conversion mode, resets free-running
// - Free-running stores one result per clock fall
// - First pulse after clear waits 7 plus threshold
// - Power-down still allows bus access and readout
// - Single mode starts all inputs on trigger fall
//------------------------------------------------------------------
package arf_pkg;
  localparam int DW = 10;
  localparam int DEPTH = 16;
  // Conversion setup fields
  localparam int CS_VREF = 0;
  localparam int CS_MODE = 1;
  localparam int CS_PD = 2;
  localparam int CS_PICK_LO = 3;
  localparam int CS_SCAN = 7;
  localparam logic [9:0] CONV_SETUP_RST = 10'h020;
  // Buffer setup fields; reset and clear act and are not kept
  localparam int BS_RESET = 0;
  localparam int BS_CLEAR = 1;
  localparam int BS_THR_LO = 2;
  localparam int BS_THR_HI = 3;
  localparam logic [9:0] BUF_SETUP_RST = 10'h000;
  localparam logic [9:0] BUF_KEEP_MASK = 10'h3fc;
  // Register select codes, {reg_sel_hi, reg_sel_lo}
  localparam logic [1:0] SEL_CONV = 2'h0;
  localparam logic [1:0] SEL_BUF = 2'h1;
  localparam logic [3:0] PIPE_FILL = 4'h7;
  localparam logic [17:0] DEV_SYNC_RST = 18'h3_ffff;
  localparam logic [10:0] HOST_SYNC_RST = 11'h7ff;
  // Timing, least times rounded up to whole cycles
  localparam int CLK_NS = 40;
  localparam int PULSE_NS = 120;
  localparam int SETUP_NS = 80;
  localparam int WR_STROBE_NS = 240;
  localparam int HOLD_NS = 240;
  localparam int RD_STROBE_NS = 480;
  localparam int GAP_NS = 240;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC = (WR_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC = (RD_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  // Host Wishbone map, byte addresses
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_LEN = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_BLK = 8'h40;
  localparam int CMD_SEL_LSB = 10;
  localparam int ST_BUSY = 0;
  localparam int ST_BLOCK = 1;
  localparam int ST_OVER = 2;
  localparam logic [4:0] LEN_RST = 5'h01;

  // Threshold level from the two select bits and the channel count
  function automatic logic [4:0] thr_level(input logic [1:0] s, input logic two);
    unique case (s)
      2'h0: thr_level = two ? 5'h02 : 5'h01;
      2'h1: thr_level = 5'h04;
      2'h2: thr_level = 5'h08;
      2'h3: thr_level = 5'h0e;
    endcase
  endfunction : thr_level
endpackage : arf_pkg

// ---- arf_link_if.sv ----
// Parallel pin link between the converter end and the host end
`timescale 1ns/1ps
interface arf_link_if;
  logic chip_sel_a_n;
  logic chip_sel_b_n;
  logic rd_n;
  logic wr_n;
  logic reg_sel_lo;
  logic reg_sel_hi;
  logic [arf_pkg::DW-1:0] host_d;
  logic host_oe_n;
  logic [arf_pkg::DW-1:0] dev_d;
  logic dev_oe_n;
  logic [arf_pkg::DW-1:0] bus_d;
  logic block_ready_pulse_n;

  // Undriven bus floats high as with pull-ups
  assign bus_d = !host_oe_n ? host_d : (!dev_oe_n ? dev_d : '1);

  modport dev (
    input chip_sel_a_n, chip_sel_b_n, rd_n, wr_n, reg_sel_lo, reg_sel_hi, bus_d,
    output dev_d, dev_oe_n, block_ready_pulse_n
  );
  modport host (
    output chip_sel_a_n, chip_sel_b_n, rd_n, wr_n, reg_sel_lo, reg_sel_hi, host_d,
    output host_oe_n,
    input bus_d, block_ready_pulse_n
  );
endinterface : arf_link_if

// ---- arf_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module arf_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] agree;

  if (W < 1) begin : g_bad_width
    $error("arf_sync needs W of at least one");
  end

  // First stage feeds only the second
  assign agree = ~(s2_q ^ s3_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_o <= (s3_q & agree) | (q_o & ~agree);
    end
  end
endmodule : arf_sync

// ---- arf_adc_end.sv ----
// Converter end: setup registers, result buffer and block pulse
`timescale 1ns/1ps
module arf_adc_end #(
  parameter int DEPTH = arf_pkg::DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  arf_link_if.dev link,
  input wire logic [arf_pkg::DW-1:0] ch_a_result_i,
  input wire logic [arf_pkg::DW-1:0] ch_b_result_i,
  input wire logic sample_clock_in_i,
  input wire logic one_shot_trigger_in_i,
  output logic [arf_pkg::DW-1:0] conv_setup_o,
  output logic [arf_pkg::DW-1:0] buf_setup_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int DW = arf_pkg::DW;

  // Pointer arithmetic wraps at a power of two; thresholds reach 14
  if (DEPTH != 16) begin : g_bad_depth
    $error("arf_adc_end supports a depth of exactly 16");
  end

  //----------------------------------------------------------------
  // Pin synchronisation
  //----------------------------------------------------------------
  logic cs_a_n;
  logic cs_b_n;
  logic rd_n;
  logic wr_n;
  logic [1:0] sel;
  logic [DW-1:0] pin_d;
  logic sclk;
  logic trig;

  arf_sync #(
    .W(18),
    .RST_VAL(arf_pkg::DEV_SYNC_RST)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({link.chip_sel_a_n, link.chip_sel_b_n, link.rd_n, link.wr_n, link.reg_sel_hi,
          link.reg_sel_lo, link.bus_d, sample_clock_in_i, one_shot_trigger_in_i}),
    .q_o({cs_a_n, cs_b_n, rd_n, wr_n, sel, pin_d, sclk, trig})
  );

  //----------------------------------------------------------------
  // Access decode
  //----------------------------------------------------------------
  logic rd_acc;
  logic wr_acc;
  logic rd_acc_q;
  logic wr_acc_q;
  logic sclk_q;
  logic trig_q;
  logic [DW-1:0] wr_data_q;
  logic [1:0] wr_sel_q;
  logic wr_end;
  logic buf_wr;
  logic soft_rst;
  logic clr;
  logic rd_start;
  logic rd_end;

  assign rd_acc = ~cs_a_n & ~cs_b_n & ~rd_n;
  assign wr_acc = ~cs_a_n & ~cs_b_n & ~wr_n;
  assign rd_start = rd_acc & ~rd_acc_q;
  assign rd_end = ~rd_acc & rd_acc_q;
  assign wr_end = wr_acc_q & ~wr_acc;
  assign buf_wr = wr_end & (wr_sel_q == arf_pkg::SEL_BUF);
  assign soft_rst = buf_wr & wr_data_q[arf_pkg::BS_RESET];
  assign clr = soft_rst | (buf_wr & wr_data_q[arf_pkg::BS_CLEAR]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_acc_q <= 1'b0;
      wr_acc_q <= 1'b0;
      sclk_q <= 1'b1;
      trig_q <= 1'b1;
    end else begin
      rd_acc_q <= rd_acc;
      wr_acc_q <= wr_acc;
      sclk_q <= sclk;
      trig_q <= trig;
    end
  end

  // Latest stable value while the strobe is low is the one applied
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_data_q <= '0;
      wr_sel_q <= arf_pkg::SEL_CONV;
    end else if (wr_acc) begin
      wr_data_q <= pin_d;
      wr_sel_q <= sel;
    end
  end

  //----------------------------------------------------------------
  // Setup registers
  //----------------------------------------------------------------
  logic [DW-1:0] conv_q;
  logic [DW-1:0] buf_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst) begin
      conv_q <= arf_pkg::CONV_SETUP_RST;
      buf_q <= arf_pkg::BUF_SETUP_RST;
    end else if (wr_end && wr_sel_q == arf_pkg::SEL_CONV) begin
      conv_q <= wr_data_q;
    end else if (buf_wr) begin
      buf_q <= wr_data_q & arf_pkg::BUF_KEEP_MASK;
    end
    // Reserved select codes fall through untouched
  end

  assign conv_setup_o = conv_q;
  assign buf_setup_o = buf_q;

  //----------------------------------------------------------------
  // Conversion events
  //----------------------------------------------------------------
  logic two_ch;
  logic free_mode;
  logic pd;
  logic sclk_fall;
  logic [3:0] fill_q;
  logic [1:0] burst_q;
  logic store;
  logic [4:0] tl;
  logic [4:0] tl_new;

  assign two_ch = conv_q[arf_pkg::CS_SCAN];
  assign free_mode = ~conv_q[arf_pkg::CS_MODE];
  assign pd = conv_q[arf_pkg::CS_PD];
  assign sclk_fall = sclk_q & ~sclk;
  assign tl = arf_pkg::thr_level(buf_q[arf_pkg::BS_THR_HI:arf_pkg::BS_THR_LO], two_ch);
  assign tl_new = arf_pkg::thr_level(wr_data_q[arf_pkg::BS_THR_HI:arf_pkg::BS_THR_LO],
                                     two_ch);
  // Power-down stops only conversions, never the bus
  assign store = ~pd & (free_mode ? (sclk_fall & (fill_q == '0)) : (burst_q != '0));

  // Pipeline fill swallows the first edges after a clear
  always_ff @(posedge clk_i) begin
    if (rst_i || clr) begin
      fill_q <= arf_pkg::PIPE_FILL;
    end else if (free_mode && sclk_fall && !pd && fill_q != '0) begin
      fill_q <= fill_q - 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || clr) begin
      burst_q <= '0;
    end else if (!free_mode && trig_q && !trig && !pd) begin
      burst_q <= two_ch ? 2'h2 : 2'h1;
    end else if (store) begin
      burst_q <= burst_q - 2'h1;
    end
  end

  //----------------------------------------------------------------
  // Buffer and pointers
  //----------------------------------------------------------------
  logic [DW-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW-1:0] thr_ptr_q;
  logic [PW-1:0] wr_next;
  logic chan_q;
  logic blk_done;
  logic [DW-1:0] word;

  assign wr_next = wr_ptr_q + 1'b1;
  assign blk_done = store & (wr_next == thr_ptr_q);
  assign word = two_ch ? (chan_q ? ch_b_result_i : ch_a_result_i)
                       : (conv_q[arf_pkg::CS_PICK_LO] ? ch_b_result_i : ch_a_result_i);

  always_ff @(posedge clk_i) begin
    if (store) begin
      mem_q[wr_next] <= word;
    end
  end

  // Clear realigns the scan so every block opens on channel A
  always_ff @(posedge clk_i) begin
    if (rst_i || clr) begin
      wr_ptr_q <= '1;
      thr_ptr_q <= PW'((buf_wr ? tl_new : tl) - 5'h01);
      chan_q <= 1'b0;
    end else begin
      if (store) begin
        wr_ptr_q <= wr_next;
        chan_q <= two_ch & ~chan_q;
      end
      if (blk_done) begin
        thr_ptr_q <= thr_ptr_q + PW'(tl);
      end else if (buf_wr) begin
        thr_ptr_q <= wr_ptr_q + PW'(tl_new);
      end
    end
  end

  //----------------------------------------------------------------
  // Host read port
  //----------------------------------------------------------------
  logic [DW-1:0] dout_q;
  logic doe_n_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || clr) begin
      rd_ptr_q <= '0;
      dout_q <= '0;
      doe_n_q <= 1'b1;
    end else if (rd_start) begin
      dout_q <= mem_q[rd_ptr_q];
      doe_n_q <= 1'b0;
    end else if (rd_end) begin
      doe_n_q <= 1'b1;
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  assign link.dev_d = dout_q;
  assign link.dev_oe_n = doe_n_q;

  //----------------------------------------------------------------
  // Block pulse
  //----------------------------------------------------------------
  logic [3:0] pcnt_q;
  logic pulse_n_q;

  // A block finishing inside a running pulse only restarts it
  always_ff @(posedge clk_i) begin
    if (rst_i || clr) begin
      pulse_n_q <= 1'b1;
      pcnt_q <= '0;
    end else if (blk_done) begin
      pulse_n_q <= 1'b0;
      pcnt_q <= 4'(arf_pkg::PULSE_CYC - 1);
    end else if (pcnt_q != '0) begin
      pcnt_q <= pcnt_q - 4'h1;
    end else begin
      pulse_n_q <= 1'b1;
    end
  end

  assign link.block_ready_pulse_n = pulse_n_q;
endmodule : arf_adc_end

// ---- arf_host_end.sv ----
// Host end: Wishbone registers driving setup writes and block reads
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/1ps
module arf_host_end #(
  parameter int DEPTH = arf_pkg::DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  arf_link_if.host link
);
  localparam int DW = arf_pkg::DW;

  if (DEPTH != 16) begin : g_bad_depth
    $error("arf_host_end supports a depth of exactly 16");
  end

  typedef enum logic [2:0] {
    HS_IDLE, HS_WSETUP, HS_WSTROBE, HS_WHOLD, HS_RSTROBE, HS_RGAP
  } arf_hst_state_t;

  logic pls_n;
  logic pls_q;
  logic [DW-1:0] pin_d;

  arf_sync #(
    .W(11),
    .RST_VAL(arf_pkg::HOST_SYNC_RST)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({link.block_ready_pulse_n, link.bus_d}),
    .q_o({pls_n, pin_d})
  );

  //----------------------------------------------------------------
  // Wishbone slave
  //----------------------------------------------------------------
  arf_hst_state_t st_q;
  logic [4:0] len_q;
  logic [11:0] cmd_q;
  logic block_q;
  logic over_q;
  logic [DW-1:0] blk_q [DEPTH];
  logic fire;
  logic wr_fire;
  logic cmd_go;
  logic stat_wr;
  logic [31:0] rdata;

  assign fire = cyc_i & stb_i & ack_o;
  assign wr_fire = fire & we_i;
  assign stat_wr = wr_fire & (adr_i == arf_pkg::ADR_STAT) & sel_i[0];
  // Reserved select codes are refused, as is any order while busy
  assign cmd_go = wr_fire & (adr_i == arf_pkg::ADR_CMD) & (&sel_i[1:0]) & (st_q == HS_IDLE)
                & ~dat_i[arf_pkg::CMD_SEL_LSB+1];

  always_comb begin
    rdata = '0;
    if (adr_i == arf_pkg::ADR_CMD) begin
      rdata = {20'h0_0000, cmd_q};
    end else if (adr_i == arf_pkg::ADR_LEN) begin
      rdata = {27'h000_0000, len_q};
    end else if (adr_i == arf_pkg::ADR_STAT) begin
      rdata = {29'h000_0000, over_q, block_q, st_q != HS_IDLE};
    end else if (adr_i[7:6] == arf_pkg::ADR_BLK[7:6]) begin
      rdata = {22'h00_0000, blk_q[adr_i[5:2]]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      if (cyc_i && stb_i && !ack_o) begin
        dat_o <= rdata;
      end
    end
  end

  // Lengths outside one to sixteen are ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      len_q <= arf_pkg::LEN_RST;
    end else if (wr_fire && adr_i == arf_pkg::ADR_LEN && sel_i[0] && dat_i[4:0] != '0
                 && 32'(dat_i[4:0]) <= DEPTH) begin
      len_q <= dat_i[4:0];
    end
  end

  //----------------------------------------------------------------
  // Link sequencing
  //----------------------------------------------------------------
  logic [3:0] cnt_q;
  logic [4:0] idx_q;
  logic [3:0] pend_q;
  logic cs_n_q;
  logic rd_n_q;
  logic wr_n_q;
  logic [1:0] hsel_q;
  logic [DW-1:0] hd_q;
  logic hoe_n_q;
  logic pls_fall;
  logic done;
  logic cnt_end;

  assign pls_fall = pls_q & ~pls_n;
  assign cnt_end = (cnt_q == '0);
  assign done = (st_q == HS_RGAP) & cnt_end & (idx_q + 5'h01 == len_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pls_q <= 1'b1;
      pend_q <= '0;
    end else begin
      pls_q <= pls_n;
      pend_q <= pend_q + {3'h0, pls_fall} - {3'h0, done};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= HS_IDLE;
      cnt_q <= '0;
      idx_q <= '0;
      cmd_q <= '0;
      cs_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      hsel_q <= arf_pkg::SEL_CONV;
      hd_q <= '0;
      hoe_n_q <= 1'b1;
    end else begin
      unique case (st_q)
        HS_IDLE: begin
          if (cmd_go) begin
            cmd_q <= dat_i[11:0];
            hsel_q <= dat_i[arf_pkg::CMD_SEL_LSB +: 2];
            hd_q <= dat_i[DW-1:0];
            hoe_n_q <= 1'b0;
            cs_n_q <= 1'b0;
            cnt_q <= 4'(arf_pkg::SETUP_CYC - 1);
            st_q <= HS_WSETUP;
          end else if (pend_q != '0) begin
            idx_q <= '0;
            cs_n_q <= 1'b0;
            rd_n_q <= 1'b0;
            cnt_q <= 4'(arf_pkg::RD_CYC - 1);
            st_q <= HS_RSTROBE;
          end
        end
        HS_WSETUP: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_end) begin
            wr_n_q <= 1'b0;
            cnt_q <= 4'(arf_pkg::WR_CYC - 1);
            st_q <= HS_WSTROBE;
          end
        end
        HS_WSTROBE: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_end) begin
            wr_n_q <= 1'b1;
            cnt_q <= 4'(arf_pkg::HOLD_CYC - 1);
            st_q <= HS_WHOLD;
          end
        end
        HS_WHOLD: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_end) begin
            cs_n_q <= 1'b1;
            hoe_n_q <= 1'b1;
            st_q <= HS_IDLE;
          end
        end
        HS_RSTROBE: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_end) begin
            rd_n_q <= 1'b1;
            cnt_q <= 4'(arf_pkg::GAP_CYC - 1);
            st_q <= HS_RGAP;
          end
        end
        HS_RGAP: begin
          cnt_q <= cnt_q - 4'h1;
          if (done) begin
            cs_n_q <= 1'b1;
            st_q <= HS_IDLE;
          end else if (cnt_end) begin
            idx_q <= idx_q + 5'h01;
            rd_n_q <= 1'b0;
            cnt_q <= 4'(arf_pkg::RD_CYC - 1);
            st_q <= HS_RSTROBE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (st_q == HS_RSTROBE && cnt_end) begin
      blk_q[idx_q[3:0]] <= pin_d;
    end
  end

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      block_q <= 1'b0;
      over_q <= 1'b0;
    end else begin
      if (done) begin
        block_q <= 1'b1;
      end else if (stat_wr && dat_i[arf_pkg::ST_BLOCK]) begin
        block_q <= 1'b0;
      end
      if (done && block_q) begin
        over_q <= 1'b1;
      end else if (stat_wr && dat_i[arf_pkg::ST_OVER]) begin
        over_q <= 1'b0;
      end
    end
  end

  assign link.chip_sel_a_n = cs_n_q;
  assign link.chip_sel_b_n = cs_n_q;
  assign link.rd_n = rd_n_q;
  assign link.wr_n = wr_n_q;
  assign {link.reg_sel_hi, link.reg_sel_lo} = hsel_q;
  assign link.host_d = hd_q;
  assign link.host_oe_n = hoe_n_q;
endmodule : arf_host_end

// ---- arf_link_monitor.sv ----
// Concurrent checks on the pin link between both ends
`timescale 1ns/1ps
module arf_link_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic chip_sel_a_n,
  input wire logic chip_sel_b_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic reg_sel_lo,
  input wire logic reg_sel_hi,
  input wire logic [arf_pkg::DW-1:0] host_d,
  input wire logic host_oe_n,
  input wire logic [arf_pkg::DW-1:0] dev_d,
  input wire logic dev_oe_n,
  input wire logic block_ready_pulse_n
);
  //----------------------------------------
  // Link assertions
  //----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_pulse_low;
    !block_ready_pulse_n [*3] ##1 block_ready_pulse_n;
  endsequence
  sequence s_wr_low;
    !wr_n [*6] ##1 wr_n;
  endsequence
  pulse_width_a: assert property ($fell(block_ready_pulse_n) |-> s_pulse_low)
    else $error("block pulse not three cycles low");
  wr_width_a: assert property ($fell(wr_n) |-> s_wr_low)
    else $error("write strobe width wrong");
  wr_data_a: assert property (!wr_n |-> !host_oe_n && $stable(host_d))
    else $error("write data not driven steady");
  wr_sel_a: assert property (!wr_n |-> !reg_sel_hi && !chip_sel_a_n && !chip_sel_b_n)
    else $error("write to reserved select or without selects");
  rd_sel_a: assert property (!rd_n |-> !chip_sel_a_n && !chip_sel_b_n && wr_n)
    else $error("read strobe without both selects");
  rd_width_a: assert property ($fell(rd_n) |-> !rd_n [*8])
    else $error("read strobe too short for the synchroniser");
  dev_drive_a: assert property ($fell(dev_oe_n) |-> !rd_n && host_oe_n)
    else $error("device drives bus outside a read");
  dev_sel_a: assert property (!dev_oe_n |-> !chip_sel_a_n && !chip_sel_b_n)
    else $error("device drives bus while not selected");
  block_seen_c: cover property ($fell(block_ready_pulse_n));
endmodule : arf_link_monitor

// ---- testbench.sv ----
// Testbench joining both ends over the link, driven through Wishbone
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_req = 1'b0;
  logic wb_we = 1'b0;
  logic [3:0] wb_sel = 4'h0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic [9:0] ch_a = 10'h000;
  logic [9:0] ch_b = 10'h000;
  logic sclk = 1'b1;
  logic trig = 1'b1;
  logic [9:0] conv_setup;
  logic [9:0] buf_setup;
  logic [31:0] rv;
  logic [9:0] exp_w [16];
  logic [4:0] tls [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
  int err_total = 0;
  int n_tests = 0;
  int pulses = 0;
  int p0;
  int tl;

  always #20 clk_i = ~clk_i;

  arf_link_if link();
  arf_adc_end i_arf_adc_end (.clk_i(clk_i), .rst_i(rst_i), .link(link), .ch_a_result_i(ch_a),
    .ch_b_result_i(ch_b), .sample_clock_in_i(sclk), .one_shot_trigger_in_i(trig),
    .conv_setup_o(conv_setup), .buf_setup_o(buf_setup));
  arf_host_end i_arf_host_end (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(wb_req), .stb_i(wb_req),
    .we_i(wb_we), .adr_i(wb_adr), .sel_i(wb_sel), .dat_i(wb_wdat), .dat_o(wb_rdat),
    .ack_o(wb_ack), .link(link));
  arf_link_monitor i_arf_link_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .chip_sel_a_n(link.chip_sel_a_n), .chip_sel_b_n(link.chip_sel_b_n), .rd_n(link.rd_n),
    .wr_n(link.wr_n), .reg_sel_lo(link.reg_sel_lo), .reg_sel_hi(link.reg_sel_hi),
    .host_d(link.host_d), .host_oe_n(link.host_oe_n), .dev_d(link.dev_d),
    .dev_oe_n(link.dev_oe_n), .block_ready_pulse_n(link.block_ready_pulse_n));

  always @(negedge link.block_ready_pulse_n) if (!rst_i) pulses++;

  //----------------------------------------
  // Tasks
  //----------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic to();
    err_total++;
    $display("wrong value at %0t: wait ran out", $time);
    final_report();
  endtask : to

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request is held until the edge that samples ack high
  // Ack and read data are taken as they stand at that rising edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    @(posedge clk_i);
    wb_req <= 1'b1;
    wb_sel <= 4'hf;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= dat;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (wb_ack === 1'b1) break;
    end
    if (i == 50) to();
    rv = wb_rdat;
    wb_req <= 1'b0;
    wb_sel <= 4'h0;
  endtask : wb

  task automatic setup(input logic [1:0] s, input logic [9:0] v);
    int i;
    wb(1'b1, arf_pkg::ADR_CMD, {20'h0_0000, s, v});
    for (i = 0; i < 50; i++) begin
      wb(1'b0, arf_pkg::ADR_STAT, 32'h0000_0000);
      if (rv[arf_pkg::ST_BUSY] === 1'b0) break;
    end
    if (i == 50) to();
    repeat (8) @(posedge clk_i);
  endtask : setup

  // Sample clock idles high and falls once per call
  task automatic edge_a(input logic [9:0] v);
    ch_a <= v;
    repeat (8) @(posedge clk_i);
    sclk <= 1'b0;
    repeat (8) @(posedge clk_i);
    sclk <= 1'b1;
  endtask : edge_a

  task automatic check_block(input int n);
    int i;
    for (i = 0; i < 200; i++) begin
      wb(1'b0, arf_pkg::ADR_STAT, 32'h0000_0000);
      if (rv[arf_pkg::ST_BLOCK] === 1'b1) break;
    end
    if (i == 200) to();
    chk(32'(rv[arf_pkg::ST_OVER]), 32'h0000_0000);
    for (i = 0; i < n; i++) begin
      wb(1'b0, arf_pkg::ADR_BLK + 8'(4 * i), 32'h0000_0000);
      chk(rv, 32'(exp_w[i]));
    end
    wb(1'b1, arf_pkg::ADR_STAT, 32'h0000_0006);
  endtask : check_block

  //----------------------------------------
  // Main sequence
  //----------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    chk(32'(conv_setup[1:0]), 32'h0000_0000);
    chk(32'(buf_setup), 32'h0000_0000);
    wb(1'b0, arf_pkg::ADR_LEN, 32'h0000_0000);
    chk(rv, 32'h0000_0001);
    wb(1'b0, 8'h20, 32'h0000_0000);
    chk(rv, 32'h0000_0000);
    $display("test reset done");
    setup(arf_pkg::SEL_CONV, 10'h001);
    chk(32'(conv_setup), 32'h0000_0001);
    for (int s = 0; s < 4; s++) begin
      tl = tls[s];
      wb(1'b1, arf_pkg::ADR_LEN, 32'(tl));
      setup(arf_pkg::SEL_BUF, {6'h00, 2'(s), 2'h2});
      chk(32'(buf_setup), 32'({6'h00, 2'(s), 2'h0}));
      p0 = pulses;
      for (int n = 0; n < 7 + tl; n++) begin
        if (n == 6 + tl) chk(32'(pulses), 32'(p0));
        edge_a(10'h100 + 10'(n));
        if (n >= 7) exp_w[n - 7] = 10'h100 + 10'(n);
      end
      repeat (8) @(posedge clk_i);
      chk(32'(pulses), 32'(p0 + 1));
      check_block(tl);
    end
    $display("test thresholds done");
    wb(1'b1, arf_pkg::ADR_LEN, 32'h0000_0002);
    setup(arf_pkg::SEL_CONV, 10'h082);
    setup(arf_pkg::SEL_BUF, 10'h002);
    for (int n = 0; n < 2; n++) begin
      ch_a <= 10'h0a0 + 10'(n);
      ch_b <= 10'h0b0 + 10'(n);
      exp_w[0] = 10'h0a0 + 10'(n);
      exp_w[1] = 10'h0b0 + 10'(n);
      repeat (4) @(posedge clk_i);
      trig <= 1'b0;
      repeat (8) @(posedge clk_i);
      trig <= 1'b1;
      check_block(2);
    end
    $display("test scan done");
    setup(arf_pkg::SEL_CONV, 10'h004);
    setup(arf_pkg::SEL_CONV, 10'h005);
    chk(32'(conv_setup), 32'h0000_0005);
    setup(2'h2, 10'h3ff);
    chk(32'(conv_setup), 32'h0000_0005);
    chk(32'(buf_setup), 32'h0000_0000);
    $display("test setup writes done");
    final_report();
  end
endmodule : testbench
